/* File: rtl/arch_regs_cfg.svh */
`ifndef ARCH_REGS_CFG_SVH
`define ARCH_REGS_CFG_SVH

// Special register numbers as carried in move instructions
`define SPN_XER        10'h001
`define SPN_LINK       10'h008
`define SPN_COUNT      10'h009
`define SPN_FCAUSE     10'h012
`define SPN_FADDR      10'h013
`define SPN_TIMER      10'h016
`define SPN_PTBASE     10'h019
`define SPN_RESUME     10'h01A
`define SPN_STSAVE     10'h01B
`define SPN_TB_RD_LO   10'h10C
`define SPN_TB_RD_HI   10'h10D
`define SPN_SCRATCH0   10'h110
`define SPN_EXTACC     10'h11A
`define SPN_TB_WR_LO   10'h11C
`define SPN_TB_WR_HI   10'h11D
`define SPN_VERSION    10'h11F
`define SPN_IMAP0      10'h210
`define SPN_DMAP0      10'h218
`define SPN_DWATCH     10'h3F5

// Machine state bit positions
`define MS_SLEEP_POS   18
`define MS_USER_POS    14
`define MS_PERF_POS    2

// Integer exception field positions
`define XF_SO_POS      31
`define XF_OV_POS      30
`define XF_CA_POS      29
`define XF_BC_LSB      0
`define XF_BC_W        7

`define RST_WORD       32'h00000000
`define RST_MSTATE     32'h00000040
// Arbitrary identification value
`define VERSION_ID     32'h0000ABCD

`endif

/* File: rtl/arch_regs_pkg.sv */
package arch_regs_pkg;
  typedef logic [31:0] word_t;
  typedef logic [63:0] dword_t;

  typedef enum logic [1:0] {
    SPR_NONE,
    SPR_READ,
    SPR_WRITE
  } spr_op_e;

  typedef struct packed {
    spr_op_e     op;
    logic [9:0]  num;
    logic [4:0]  integer_file;
  } spr_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic        dataFault;
    logic [31:0] addr;
    logic [31:0] cause;
  } exc_req_s;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [31:0] data;
  } int_wr_s;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [63:0] data;
  } flt_wr_s;
endpackage : arch_regs_pkg

/* File: rtl/cpu_arch_register_set.sv */
`timescale 1ns/1ns
`include "arch_regs_cfg.svh"

module cpu_arch_register_set (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire arch_regs_pkg::int_wr_s intWr,
  input  wire logic [4:0]             intRdA,
  input  wire logic [4:0]             intRdB,
  input  wire arch_regs_pkg::flt_wr_s fltWr,
  input  wire logic [4:0]             fltRdA,
  input  wire logic [7:0]             condWe,
  input  wire logic [31:0]            condIn,
  input  wire logic [2:0]             condSel,
  input  wire logic                   fpStatWe,
  input  wire logic [31:0]            fpStatIn,
  input  wire logic                   xerWe,
  input  wire logic [31:0]            xerIn,
  input  wire logic                   msWe,
  input  wire logic [31:0]            msIn,
  input  wire logic                   segWe,
  input  wire logic                   segRd,
  input  wire logic [3:0]             segIdx,
  input  wire logic [3:0]             fetchSeg,
  input  wire arch_regs_pkg::spr_req_s sprReq,
  input  wire logic [31:0]            sprWrData,
  input  wire logic                   branchLink,
  input  wire logic [31:0]            returnAddr,
  input  wire logic                   branchCount,
  input  wire arch_regs_pkg::exc_req_s excReq,
  input  wire logic                   rfiExec,
  output logic [31:0]                 intDataA,
  output logic [31:0]                 intDataB,
  output logic [63:0]                 fltDataA,
  output logic [3:0]                  condField,
  output logic [31:0]                 condAll,
  output logic [31:0]                 fpStatus,
  output logic [31:0]                 xerOut,
  output logic [31:0]                 msOut,
  output logic [31:0]                 segData,
  output logic [31:0]                 segFetch,
  output logic [31:0]                 sprRdData,
  output logic                        sprRdValid,
  output logic                        privFault,
  output logic [31:0]                 linkOut,
  output logic                        countZero,
  output logic [31:0]                 resumeOut,
  output logic                        timerEvent,
  output logic                        extAccessEn,
  output logic [63:0]                 timeOut
);

  logic        rstMeta;
  logic        rstSync;
  // Reset takes hold at once; release waits two edges to stay clear of clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  logic [31:0] intFile [0:31];
  logic [63:0] fltFile [0:31];
  logic [31:0] segMain   [0:15];
  logic [31:0] segShadow [0:15];
  // block maps: 0-7 insn, 8-15 data
  logic [31:0] blockMap  [0:15];
  logic [31:0] scratch   [0:3];

  logic [31:0] cond_reg;
  logic [31:0] fpStat_reg;
  logic [31:0] xer_reg;
  logic [31:0] ms_reg;
  logic [31:0] link_reg;
  logic [31:0] count_reg;
  logic [31:0] fAddr_reg;
  logic [31:0] fCause_reg;
  logic [31:0] timer_reg;
  logic [31:0] ptBase_reg;
  logic [31:0] resume_reg;
  logic [31:0] stSave_reg;
  logic [31:0] extAcc_reg;
  logic [31:0] dWatch_reg;
  logic [63:0] time_reg;

  wire userMode = ms_reg[`MS_USER_POS];
  wire [9:0] num = sprReq.num;
  wire isRead  = sprReq.op == arch_regs_pkg::SPR_READ;
  wire isWrite = sprReq.op == arch_regs_pkg::SPR_WRITE;

  // Decode of special register numbers
  wire hitXer   = num == `SPN_XER;
  wire hitLink  = num == `SPN_LINK;
  wire hitCount = num == `SPN_COUNT;
  wire hitCause = num == `SPN_FCAUSE;
  wire hitFAddr = num == `SPN_FADDR;
  wire hitTimer = num == `SPN_TIMER;
  wire hitPtb   = num == `SPN_PTBASE;
  wire hitRes   = num == `SPN_RESUME;
  wire hitSts   = num == `SPN_STSAVE;
  wire hitTbRL  = num == `SPN_TB_RD_LO;
  wire hitTbRH  = num == `SPN_TB_RD_HI;
  wire hitScr   = num[9:2] == `SPN_SCRATCH0 >> 2;
  wire hitExt   = num == `SPN_EXTACC;
  wire hitTbWL  = num == `SPN_TB_WR_LO;
  wire hitTbWH  = num == `SPN_TB_WR_HI;
  wire hitVer   = num == `SPN_VERSION;
  wire hitMap   = num[9:4] == `SPN_IMAP0 >> 4;
  wire hitWatch = num == `SPN_DWATCH;
  wire [1:0] scrIdx = num[1:0];
  wire [3:0] mapIdx = num[3:0];

  wire userReg = hitXer | hitLink | hitCount | hitCause | hitFAddr |
                 hitTbRL | hitTbRH;
  wire supReg  = hitTimer | hitPtb | hitRes | hitSts | hitScr | hitExt |
                 hitTbWL | hitTbWH | hitVer | hitMap | hitWatch;
  wire denied  = (isRead | isWrite) & (supReg | (isWrite & hitTbRL) |
                 (isWrite & hitTbRH)) & userMode;
  // machine state and segment moves refused in user mode
  wire msDenied  = msWe & userMode;
  wire segDenied = (segWe | segRd) & userMode;
  wire msWrite   = msWe & ~userMode;
  wire segWrite  = segWe & ~userMode;
  wire segRead   = segRd & ~userMode;
  // privileged fault raised instead of access
  wire privNext = denied | msDenied | segDenied;
  wire doWrite  = isWrite & ~denied;
  wire doRead   = isRead & ~denied & (userReg | supReg);

  logic [31:0] sprMux;
  always_comb begin
    sprMux = `RST_WORD;
    unique case (1'b1)
      hitXer:   sprMux = xer_reg;
      hitLink:  sprMux = link_reg;
      hitCount: sprMux = count_reg;
      hitCause: sprMux = fCause_reg;
      hitFAddr: sprMux = fAddr_reg;
      hitTimer: sprMux = timer_reg;
      hitPtb:   sprMux = ptBase_reg;
      hitRes:   sprMux = resume_reg;
      hitSts:   sprMux = stSave_reg;
      hitTbRL:  sprMux = time_reg[31:0];
      hitTbRH:  sprMux = time_reg[63:32];
      // Write-side numbers read back the live halves instead of zero
      hitTbWL:  sprMux = time_reg[31:0];
      hitTbWH:  sprMux = time_reg[63:32];
      hitScr:   sprMux = scratch[scrIdx];
      hitExt:   sprMux = extAcc_reg;
      hitVer:   sprMux = `VERSION_ID;
      hitMap:   sprMux = blockMap[mapIdx];
      hitWatch: sprMux = dWatch_reg;
      default:  sprMux = `RST_WORD;
    endcase
  end

  wire [31:0] countDec = count_reg - 32'h00000001;
  wire        wrCount  = doWrite & hitCount;
  wire [31:0] countNext = wrCount ? sprWrData :
                          branchCount ? countDec : count_reg;
  wire [31:0] timerNext = (doWrite & hitTimer) ? sprWrData :
                          timer_reg - 32'h00000001;
  // Timer wraps past zero; software reloads it for the next event
  wire        timerFire = ~(doWrite & hitTimer) &
                          (timer_reg == 32'h00000000);
  wire [63:0] timeInc  = time_reg + 64'h0000000000000001;
  wire [63:0] timeNext = (doWrite & hitTbWL) ? {time_reg[63:32], sprWrData} :
                         (doWrite & hitTbWH) ? {sprWrData, time_reg[31:0]} :
                         timeInc;

  logic [31:0] condNext;
  always_comb begin
    condNext = cond_reg;
    for (int f = 0; f < 8; f++) begin
      if (condWe[f]) begin
        condNext[f*4 +: 4] = condIn[f*4 +: 4];
      end
    end
  end

  // machine state: exception save, return restore
  wire [31:0] msNext = excReq.valid ?
                       (ms_reg & ~(32'h1 << `MS_USER_POS)) :
                       rfiExec ? stSave_reg :
                       msWrite ? msIn : ms_reg;

  always_ff @(posedge clk) begin
    if (intWr.we) begin
      intFile[intWr.addr] <= intWr.data;
    end
    if (fltWr.we) begin
      fltFile[fltWr.addr] <= fltWr.data;
    end
    if (segWrite) begin
      segMain[segIdx]   <= sprWrData;
      segShadow[segIdx] <= sprWrData;
    end
    if (doWrite & hitScr) begin
      scratch[scrIdx] <= sprWrData;
    end
    if (doWrite & hitMap) begin
      blockMap[mapIdx] <= sprWrData;
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      cond_reg   <= `RST_WORD;
      fpStat_reg <= `RST_WORD;
      xer_reg    <= `RST_WORD;
      ms_reg     <= `RST_MSTATE;
      link_reg   <= `RST_WORD;
      count_reg  <= `RST_WORD;
      fAddr_reg  <= `RST_WORD;
      fCause_reg <= `RST_WORD;
      timer_reg  <= `RST_WORD;
      ptBase_reg <= `RST_WORD;
      resume_reg <= `RST_WORD;
      stSave_reg <= `RST_WORD;
      extAcc_reg <= `RST_WORD;
      dWatch_reg <= `RST_WORD;
      time_reg   <= 64'h0000000000000000;
    end else begin
      cond_reg   <= condNext;
      fpStat_reg <= fpStatWe ? fpStatIn : fpStat_reg;
      xer_reg    <= (doWrite & hitXer) ? sprWrData :
                    xerWe ? xerIn : xer_reg;
      ms_reg     <= msNext;
      link_reg   <= (doWrite & hitLink) ? sprWrData :
                    branchLink ? returnAddr : link_reg;
      count_reg  <= countNext;
      fAddr_reg  <= (excReq.valid & excReq.dataFault) ? excReq.addr :
                    (doWrite & hitFAddr) ? sprWrData : fAddr_reg;
      fCause_reg <= (excReq.valid & excReq.dataFault) ? excReq.cause :
                    (doWrite & hitCause) ? sprWrData : fCause_reg;
      timer_reg  <= timerNext;
      ptBase_reg <= (doWrite & hitPtb) ? sprWrData : ptBase_reg;
      resume_reg <= excReq.valid ? excReq.pc :
                    (doWrite & hitRes) ? sprWrData : resume_reg;
      stSave_reg <= excReq.valid ? ms_reg :
                    (doWrite & hitSts) ? sprWrData : stSave_reg;
      extAcc_reg <= (doWrite & hitExt) ? sprWrData : extAcc_reg;
      dWatch_reg <= (doWrite & hitWatch) ? sprWrData : dWatch_reg;
      time_reg   <= timeNext;
    end
  end

  // Registered outputs; reads see state from the previous cycle
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      intDataA    <= `RST_WORD;
      intDataB    <= `RST_WORD;
      fltDataA    <= 64'h0000000000000000;
      condField   <= 4'h0;
      condAll     <= `RST_WORD;
      fpStatus    <= `RST_WORD;
      xerOut      <= `RST_WORD;
      msOut       <= `RST_MSTATE;
      segData     <= `RST_WORD;
      segFetch    <= `RST_WORD;
      sprRdData   <= `RST_WORD;
      sprRdValid  <= 1'b0;
      privFault   <= 1'b0;
      linkOut     <= `RST_WORD;
      countZero   <= 1'b0;
      resumeOut   <= `RST_WORD;
      timerEvent  <= 1'b0;
      extAccessEn <= 1'b0;
      timeOut     <= 64'h0000000000000000;
    end else begin
      intDataA    <= intFile[intRdA];
      intDataB    <= intFile[intRdB];
      fltDataA    <= fltFile[fltRdA];
      condField   <= cond_reg[condSel*4 +: 4];
      condAll     <= cond_reg;
      fpStatus    <= fpStat_reg;
      xerOut      <= xer_reg;
      // sleep and perf mark bits carried
      msOut       <= ms_reg;
      segData     <= segRead ? segMain[segIdx] : segData;
      segFetch    <= segShadow[fetchSeg];
      sprRdData   <= doRead ? sprMux : sprRdData;
      sprRdValid  <= doRead;
      privFault   <= privNext;
      linkOut     <= link_reg;
      countZero   <= branchCount & ~wrCount & (countDec == 32'h00000000);
      resumeOut   <= resume_reg;
      timerEvent  <= timerFire;
      extAccessEn <= extAcc_reg[31];
      timeOut     <= time_reg;
    end
  end

endmodule : cpu_arch_register_set

/* File: bench/cpu_arch_register_set_assertions.sv */
`timescale 1ns/1ns
`include "arch_regs_cfg.svh"
module arch_regs_checker (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire arch_regs_pkg::spr_req_s sprReq,
  input wire logic [31:0]             msOut,
  input wire logic                    msWe,
  input wire logic                    segWe,
  input wire logic                    segRd,
  input wire logic                    sprRdValid,
  input wire logic                    privFault,
  input wire logic                    branchLink,
  input wire logic [31:0]             returnAddr,
  input wire logic [31:0]             linkOut,
  input wire logic                    branchCount,
  input wire logic                    countZero,
  input wire arch_regs_pkg::exc_req_s excReq,
  input wire logic [31:0]             resumeOut
);
  logic [31:0] pcHold;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Last exception address, so resume can be judged over a short window
  always_ff @(posedge clk) if (excReq.valid) pcHold <= excReq.pc;
  priv_deny_a: assert property (
    sprReq.op == arch_regs_pkg::SPR_READ && sprReq.num == `SPN_TIMER
    |=> privFault == msOut[`MS_USER_POS] &&
    sprRdValid == !msOut[`MS_USER_POS])
    else $error("user read of timer not refused");
  link_read_a: assert property (
    sprReq.op == arch_regs_pkg::SPR_READ
    && sprReq.num == `SPN_LINK |=> sprRdValid)
    else $error("supervisor link read gave no valid");
  link_capture_a: assert property (
    branchLink && sprReq.op == arch_regs_pkg::SPR_NONE
    |=> ##1 linkOut == $past(returnAddr, 2))
    else $error("link did not capture return address");
  resume_save_a: assert property (
    excReq.valid |=> ##[0:1] resumeOut == pcHold)
    else $error("resume address not saved");
  user_clear_a: assert property (
    excReq.valid |=> ##[0:1] !msOut[`MS_USER_POS])
    else $error("exception left user mode set");
  count_zero_a: assert property (
    countZero |-> $past(branchCount))
    else $error("count zero without branch-and-count");
  valid_cause_a: assert property (
    sprRdValid |-> $past(sprReq.op) == arch_regs_pkg::SPR_READ &&
    (!privFault || $past(msWe) || $past(segWe) || $past(segRd)))
    else $error("read valid without allowed read");
  fault_cause_a: assert property (
    privFault |-> $past(sprReq.op) != arch_regs_pkg::SPR_NONE ||
    $past(msWe) || $past(segWe) || $past(segRd))
    else $error("privilege fault without access");
  ms_guard_a: assert property (
    msWe && sprReq.op == arch_regs_pkg::SPR_NONE && !segWe && !segRd
    |=> privFault == msOut[`MS_USER_POS])
    else $error("machine state move privilege not enforced");
endmodule : arch_regs_checker

/* File: bench/exec_unit_model.sv */
`timescale 1ns/1ns
module exec_unit_model (
  input  wire logic             clk,
  output arch_regs_pkg::spr_req_s sprReq,
  output logic [31:0]           sprWrData,
  output arch_regs_pkg::exc_req_s excReq,
  output logic                  rfiExec,
  output logic                  branchLink,
  output logic [31:0]           returnAddr,
  output logic                  branchCount,
  output logic                  segWe,
  output logic                  segRd,
  output logic [3:0]            segIdx
);
  initial begin
    sprReq = '0;
    sprWrData = 32'h00000000;
    excReq = '0;
    {rfiExec, branchLink, branchCount, segWe, segRd} = 5'h00;
    returnAddr = 32'h00000000;
    segIdx = 4'h0;
  end
  // Each request lives exactly one edge; release lands a half cycle later
  task automatic spr(input arch_regs_pkg::spr_op_e op,
                     input logic [9:0] num, input logic [31:0] d);
    @(negedge clk);
    sprReq = '{op, num, 5'h00};
    sprWrData = d;
    @(negedge clk);
    sprReq = '0;
  endtask : spr
  task automatic exc(input logic [31:0] pc, a, c);
    @(negedge clk);
    excReq = '{1'b1, pc, 1'b1, a, c};
    @(negedge clk);
    excReq = '0;
  endtask : exc
  task automatic ctl(input logic bl, bc, rf, input logic [31:0] ra);
    @(negedge clk);
    {branchLink, branchCount, rfiExec} = {bl, bc, rf};
    returnAddr = ra;
    @(negedge clk);
    {branchLink, branchCount, rfiExec} = 3'h0;
  endtask : ctl
  task automatic seg(input logic [3:0] idx, input logic [31:0] d);
    @(negedge clk);
    {segWe, segIdx, sprWrData} = {1'b1, idx, d};
    @(negedge clk);
    {segWe, segRd} = 2'h1;
    @(negedge clk);
    segRd = 1'b0;
  endtask : seg
endmodule : exec_unit_model

/* File: bench/cpu_arch_register_set_bench.sv */
`timescale 1ns/1ns
`include "arch_regs_cfg.svh"
module cpu_arch_register_set_bench;
  logic clk, rstn, fpStatWe, xerWe, msWe, segWe, segRd, branchLink;
  logic branchCount, rfiExec, sprRdValid, privFault, countZero;
  logic timerEvent, extAccessEn;
  arch_regs_pkg::int_wr_s  intWr;
  arch_regs_pkg::flt_wr_s  fltWr;
  arch_regs_pkg::spr_req_s sprReq;
  arch_regs_pkg::exc_req_s excReq;
  logic [4:0]  intRdA, intRdB, fltRdA;
  logic [7:0]  condWe;
  logic [2:0]  condSel;
  logic [3:0]  segIdx, fetchSeg, condField;
  logic [31:0] condIn, fpStatIn, xerIn, msIn, sprWrData, returnAddr;
  logic [31:0] intDataA, intDataB, condAll, fpStatus, xerOut, msOut;
  logic [31:0] segData, segFetch, sprRdData, linkOut, resumeOut;
  logic [63:0] fltDataA, timeOut;
  int          nMismatch, checkCount, i;
  localparam logic [9:0] NUMS [10] = '{`SPN_LINK, `SPN_XER, `SPN_FCAUSE,
    `SPN_FADDR, `SPN_PTBASE, `SPN_SCRATCH0, `SPN_IMAP0, `SPN_DMAP0,
    `SPN_DWATCH, `SPN_STSAVE};

  cpu_arch_register_set u_dut (.*);
  exec_unit_model u_exec (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [63:0] e, g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    if (nMismatch == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    u_exec.spr(arch_regs_pkg::SPR_WRITE, n, d);
  endtask : wr
  task automatic rd(input logic [9:0] n, input logic [31:0] e);
    u_exec.spr(arch_regs_pkg::SPR_READ, n, 32'h00000000);
    chk("sprRdValid", 64'h1, {63'h0, sprRdValid});
    chk("sprRdData", {32'h0, e}, {32'h0, sprRdData});
  endtask : rd
  task automatic t_files();
    @(negedge clk);
    intWr = '{1'b1, 5'h1F, 32'hDEADBEEF};
    fltWr = '{1'b1, 5'h00, 64'h0123456789ABCDEF};
    condWe = 8'h80;
    {condIn, condSel} = {32'hFFFFFFFF, 3'h7};
    {fpStatWe, fpStatIn, xerWe, xerIn} = {1'b1, 32'h00000F0F,
                                          1'b1, 32'hE000007F};
    @(negedge clk);
    {intWr, fltWr, condWe, fpStatWe, xerWe} = '0;
    {intRdA, intRdB, fltRdA} = {5'h1F, 5'h1F, 5'h00};
    @(negedge clk);
    chk("intDataA", 64'hDEADBEEF, {32'h0, intDataA});
    chk("intDataB", 64'hDEADBEEF, {32'h0, intDataB});
    chk("fltDataA", 64'h0123456789ABCDEF, fltDataA);
    chk("condField", 64'hF, {60'h0, condField});
    chk("condAll", 64'hF, {60'h0, condAll[31:28]});
    chk("fpStatus", 64'hF0F, {32'h0, fpStatus});
    chk("xerOut", 64'hE000007F, {32'h0, xerOut});
  endtask : t_files
  task automatic t_spr();
    for (i = 0; i < 10; i++) begin
      wr(NUMS[i], {22'h0, NUMS[i]} ^ 32'h5A5A0000);
      rd(NUMS[i], {22'h0, NUMS[i]} ^ 32'h5A5A0000);
    end
    wr(`SPN_VERSION, 32'hFFFFFFFF);
    rd(`SPN_VERSION, `VERSION_ID);
    u_exec.spr(arch_regs_pkg::SPR_READ, 10'h3FF, 32'h00000000);
    chk("unknownValid", 64'h0, {63'h0, sprRdValid});
  endtask : t_spr
  task automatic t_user_exc();
    @(negedge clk);
    {msWe, msIn} = {1'b1, 32'h00044044};
    @(negedge clk);
    msWe = 1'b0;
    @(negedge clk);
    chk("msOut", 64'h44044, {32'h0, msOut});
    u_exec.spr(arch_regs_pkg::SPR_READ, `SPN_TIMER, 32'h00000000);
    chk("privFault", 64'h1, {63'h0, privFault});
    wr(`SPN_TB_WR_HI, 32'h00000099);
    chk("privFaultTb", 64'h1, {63'h0, privFault});
    rd(`SPN_LINK, 32'h5A5A0008);
    u_exec.exc(32'h00001230, 32'h0000BEE0, 32'h02000000);
    @(negedge clk);
    chk("resumeOut", 64'h1230, {32'h0, resumeOut});
    chk("msOutExc", 64'h40044, {32'h0, msOut});
    rd(`SPN_FADDR, 32'h0000BEE0);
    rd(`SPN_FCAUSE, 32'h02000000);
    rd(`SPN_STSAVE, 32'h00044044);
    u_exec.ctl(1'b0, 1'b0, 1'b1, 32'h00000000);
    @(negedge clk);
    chk("msOutRfi", 64'h44044, {32'h0, msOut});
    {msWe, msIn} = {1'b1, `RST_MSTATE};
    @(negedge clk);
    msWe = 1'b0;
    chk("privFaultMs", 64'h1, {63'h0, privFault});
    @(negedge clk);
    chk("msOutKept", 64'h44044, {32'h0, msOut});
    // User level cannot move to machine state; an exception leaves it
    u_exec.exc(32'h00000000, 32'h00000000, 32'h00000000);
  endtask : t_user_exc
  task automatic t_misc();
    wr(`SPN_COUNT, 32'h00000001);
    u_exec.ctl(1'b0, 1'b1, 1'b0, 32'h00000000);
    chk("countZero", 64'h1, {63'h0, countZero});
    u_exec.ctl(1'b1, 1'b0, 1'b0, 32'h00004444);
    @(negedge clk);
    chk("linkOut", 64'h4444, {32'h0, linkOut});
    wr(`SPN_TB_WR_HI, 32'h00000077);
    @(negedge clk);
    chk("timeHi", 64'h77, {32'h0, timeOut[63:32]});
    wr(`SPN_EXTACC, 32'h80000000);
    @(negedge clk);
    chk("extAccessEn", 64'h1, {63'h0, extAccessEn});
    fetchSeg = 4'h5;
    u_exec.seg(4'h5, 32'h00ABC005);
    chk("segData", 64'hABC005, {32'h0, segData});
    chk("segFetch", 64'hABC005, {32'h0, segFetch});
    wr(`SPN_TIMER, 32'h00000003);
    for (i = 0; i < 12 && timerEvent !== 1'b1; i++) @(negedge clk);
    chk("timerEvent", 64'h1, {63'h0, timerEvent});
  endtask : t_misc

  initial begin
    {rstn, fpStatWe, xerWe, msWe} = 4'h0;
    {intWr, fltWr, condWe, condSel} = '0;
    {intRdA, intRdB, fltRdA, fetchSeg} = '0;
    {condIn, fpStatIn, xerIn, msIn} = '0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_files();
    t_spr();
    t_user_exc();
    t_misc();
    conclude();
  end
  initial begin
    #40000;
    nMismatch++;
    conclude();
  end
endmodule : cpu_arch_register_set_bench

bind cpu_arch_register_set arch_regs_checker u_chk (.clk(clk), .rstn(rstn),
  .sprReq(sprReq), .msOut(msOut), .msWe(msWe), .segWe(segWe),
  .segRd(segRd), .sprRdValid(sprRdValid),
  .privFault(privFault), .branchLink(branchLink), .returnAddr(returnAddr),
  .linkOut(linkOut), .branchCount(branchCount), .countZero(countZero),
  .excReq(excReq), .resumeOut(resumeOut));
